// [lpt_dev.sv]
`timescale 1ns/100ps
`default_nettype none
// How it works
// - emitter pulsed with programmable duty
// - hold 16-bit upper and lower light limits
// - light irq on leaving limit window
// - integration code bits 7:6 selects time
// - light needs 1/2/4/8 consecutive outside results
// - 8-bit upper and lower proximity limits
// - proximity needs 1..4 consecutive beyond results
// - every command register reads back
// - light word: low byte, high byte, one read
// - proximity result from one register
// - both irqs share one low pin
// - registers stay accessible while irq asserted
// - proximity irq above upper or below lower
// - outside logic mode any flag set pulls pin low
// - reading cause register clears flags, releases pin
// - logic mode: pin low while object near
// - logic mode pin shows proximity only
// - between limits no proximity irq
// - host reads data after irq arrives
// - cause bits 7,6,5,4,1,0 as listed
// - answer at target address 0x51
module lpt_dev (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  lpt_link_if.dev          link,
  input  wire logic [15:0] light_result_i,
  input  wire logic        light_valid_i,
  input  wire logic [7:0]  prox_result_i,
  input  wire logic        prox_valid_i,
  input  wire logic        prox_saturated_i,
  input  wire logic        sunlight_protect_i,
  output logic             emitter_drive_pin_o,
  output logic [1:0]       light_integration_time_o
);
  import lpt_pkg::*;

  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rst_m;
    logic        rst_s;
    logic        busy;
    logic [5:0]  cnt;
    logic [31:0] sh;
    logic        rd_act;
    logic        rd_tgl;
    logic        wr_tgl;
    logic [7:0]  cmd;
    logic [7:0]  wcmd;
    logic [15:0] wdata;
  } lpt_lk_s;

  typedef struct packed {
    logic        wr_m;
    logic        wr_s;
    logic        wr_p;
    logic        rd_m;
    logic        rd_s;
    logic        rd_p;
    logic [15:0] light_cfg;
    logic [15:0] light_upper;
    logic [15:0] light_lower;
    logic [15:0] prox_cfg;
    logic [15:0] prox_limits;
    logic [7:0]  prox_result;
    logic [15:0] light_result;
    logic [7:0]  flags;
    logic [3:0]  lcnt;
    logic [1:0]  pcnt;
    logic        pside;
    logic        near;
    logic [15:0] rd_hold;
    logic [3:0]  emit_cnt;
    logic        emit;
    logic        irq_oe_n;
  } lpt_rf_s;

  lpt_lk_s     lq;
  lpt_lk_s     ld;
  lpt_rf_s     rq;
  lpt_rf_s     rd;
  logic [15:0] hdr;
  logic [31:0] sh_n;
  logic [3:0]  bit_idx;
  logic [3:0]  llim;
  logic [1:0]  plim;
  logic [1:0]  peff;
  logic        lhi;
  logic        llo;
  logic        pnear;
  logic        pfar;
  logic [7:0]  setf;
  logic [7:0]  clrf;

  // ----------------------------------------------------------------
  // link domain: frame receiver on the link clock
  // ----------------------------------------------------------------
  // reset reaches this domain through two flops; the host keeps the clock running during reset
  always_comb begin : lk_next
    ld       = lq;
    sh_n     = {lq.sh[30:0], link.sda};
    hdr      = sh_n[15:0];
    ld.rst_m = rst_i;
    ld.rst_s = lq.rst_m;
    if (lq.rst_s) begin
      ld.busy   = 1'b0;
      ld.cnt    = 6'h00;
      ld.rd_act = 1'b0;
      ld.rd_tgl = 1'b0;
      ld.wr_tgl = 1'b0;
    end else if (!lq.busy) begin
      if (!link.sda) begin
        ld.busy   = 1'b1;
        ld.cnt    = 6'h00;
        ld.rd_act = 1'b0;
      end
    end else begin
      ld.sh  = sh_n;
      ld.cnt = lq.cnt + 6'h01;
      // header done: address match and read bit start the answer
      if (lq.cnt == 6'(FRAME_HDR - 1) && hdr[15:9] == LPT_DEV_ADDR && hdr[8]) begin
        ld.rd_act = 1'b1;
        ld.cmd    = hdr[7:0];
        ld.rd_tgl = ~lq.rd_tgl;
      end
      if (lq.cnt == 6'(FRAME_BITS - 1)) begin
        ld.busy   = 1'b0;
        ld.rd_act = 1'b0;
        if (sh_n[31:25] == LPT_DEV_ADDR && !sh_n[24]) begin
          ld.wcmd   = sh_n[23:16];
          ld.wdata  = {sh_n[7:0], sh_n[15:8]};
          ld.wr_tgl = ~lq.wr_tgl;
        end
      end
    end
  end

  always_ff @(posedge link.scl) begin : lk_reg
    lq <= ld;
  end

  // answer bits: low byte then high byte, each msb first; the word is held still by the host pause
  assign bit_idx         = {lq.cnt[3], ~lq.cnt[2:0]};
  assign link.sda_d_o    = 1'b0;
  assign link.sda_d_oe_n = ~(lq.rd_act & ~rq.rd_hold[bit_idx]);

  // ----------------------------------------------------------------
  // core domain: registers, persistence, flags, pin
  // ----------------------------------------------------------------
  always_comb begin : rf_next
    rd      = rq;
    rd.wr_m = lq.wr_tgl;
    rd.wr_s = rq.wr_m;
    rd.wr_p = rq.wr_s;
    rd.rd_m = lq.rd_tgl;
    rd.rd_s = rq.rd_m;
    rd.rd_p = rq.rd_s;
    setf    = 8'h00;
    clrf    = 8'h00;
    llim    = 4'((4'h1 << rq.light_cfg[LCFG_PERS_POS +: 2]) - 4'h1);
    plim    = rq.prox_cfg[PCFG_PERS_POS +: 2];
    lhi     = light_result_i > rq.light_upper;
    llo     = light_result_i < rq.light_lower;
    pnear   = prox_result_i > rq.prox_limits[PLIM_UPPER +: 8];
    pfar    = prox_result_i < rq.prox_limits[7:0];
    peff    = (rq.pside == pnear) ? rq.pcnt : 2'h0;
    // host writes land here whatever the pin shows
    if (rq.wr_s != rq.wr_p) begin
      case (lq.wcmd)
        CMD_LIGHT_CFG:   rd.light_cfg   = lq.wdata;
        CMD_LIGHT_UPPER: rd.light_upper = lq.wdata;
        CMD_LIGHT_LOWER: rd.light_lower = lq.wdata;
        CMD_PROX_CFG:    rd.prox_cfg    = lq.wdata;
        CMD_PROX_LIMITS: rd.prox_limits = lq.wdata;
        default:         rd.prox_cfg    = rq.prox_cfg;
      endcase
    end
    // read answer; unmapped codes read zero
    if (rq.rd_s != rq.rd_p) begin
      case (lq.cmd)
        CMD_LIGHT_CFG:    rd.rd_hold = rq.light_cfg;
        CMD_LIGHT_UPPER:  rd.rd_hold = rq.light_upper;
        CMD_LIGHT_LOWER:  rd.rd_hold = rq.light_lower;
        CMD_PROX_CFG:     rd.rd_hold = rq.prox_cfg;
        CMD_PROX_LIMITS:  rd.rd_hold = rq.prox_limits;
        CMD_PROX_RESULT:  rd.rd_hold = {8'h00, rq.prox_result};
        CMD_LIGHT_RESULT: rd.rd_hold = rq.light_result;
        CMD_IRQ_CAUSE: begin
          rd.rd_hold = {rq.flags, 8'h00};
          clrf       = rq.flags;
        end
        default:          rd.rd_hold = 16'h0000;
      endcase
    end
    // light persistence: count consecutive outside results, restart inside
    if (light_valid_i) begin
      rd.light_result = light_result_i;
      if (lhi || llo) begin
        if (rq.lcnt >= llim) begin
          setf[FLG_LHIGH] = lhi & rq.light_cfg[LCFG_IRQ_EN];
          setf[FLG_LLOW]  = llo & rq.light_cfg[LCFG_IRQ_EN];
        end else begin
          rd.lcnt = rq.lcnt + 4'h1;
        end
      end else begin
        rd.lcnt = 4'h0;
      end
    end
    // proximity persistence per side; between the limits nothing fires
    if (prox_valid_i) begin
      rd.prox_result = prox_result_i;
      if (pnear || pfar) begin
        rd.pside = pnear;
        if (peff >= plim) begin
          rd.near          = pnear;
          setf[FLG_NEAR]   = pnear & rq.prox_cfg[PCFG_SEL_POS];
          setf[FLG_FAR]    = pfar & rq.prox_cfg[PCFG_SEL_POS + 1];
          rd.pcnt          = peff;
        end else begin
          rd.pcnt = peff + 2'h1;
        end
      end else begin
        rd.pcnt = 2'h0;
      end
    end
    setf[FLG_SAT] = prox_saturated_i & (|rq.prox_cfg[PCFG_SEL_POS +: 2]);
    setf[FLG_SUN] = sunlight_protect_i & (|rq.prox_cfg[PCFG_SEL_POS +: 2]);
    // a set in the clearing cycle survives the read
    rd.flags = (rq.flags & ~clrf) | setf;
    // one shared pin; logic mode shows only the proximity state
    rd.irq_oe_n = rq.prox_cfg[PCFG_MODE] ? ~rd.near : ~(|rd.flags);
    // emitter: on for 2, 4, 8 or 16 of 16 cycles; more on-time costs current
    rd.emit_cnt = rq.emit_cnt + 4'h1;
    rd.emit     = {1'b0, rq.emit_cnt} < (5'h02 << rq.prox_cfg[PCFG_DUTY_POS +: 2]);
    if (rst_i) begin
      rd             = '0;
      rd.light_cfg   = LIGHT_CFG_RST;
      rd.light_upper = LIGHT_UPPER_RST;
      rd.light_lower = LIGHT_LOWER_RST;
      rd.prox_cfg    = PROX_CFG_RST;
      rd.prox_limits = PROX_LIMITS_RST;
      rd.irq_oe_n    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin : rf_reg
    rq <= rd;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.irq_d_o             = 1'b0;
  assign link.irq_d_oe_n          = rq.irq_oe_n;
  assign emitter_drive_pin_o      = rq.emit;
  assign light_integration_time_o = rq.light_cfg[LCFG_IT_POS +: 2];
endmodule // lpt_dev
`default_nettype wire

// [lpt_pkg.sv]
`default_nettype none
package lpt_pkg;
  // ----------------------------------------------------------------
  // link framing and addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] LPT_DEV_ADDR  = 7'h51;
  localparam int         FRAME_HDR     = 16;
  localparam int         FRAME_BITS    = 32;
  localparam int         SCL_HALF_DEF  = 4;
  localparam int         RD_PAUSE_DEF  = 16;

  // ----------------------------------------------------------------
  // command codes (register index)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_LIGHT_CFG    = 8'h00;
  localparam logic [7:0] CMD_LIGHT_UPPER  = 8'h01;
  localparam logic [7:0] CMD_LIGHT_LOWER  = 8'h02;
  localparam logic [7:0] CMD_PROX_CFG     = 8'h03;
  localparam logic [7:0] CMD_PROX_LIMITS  = 8'h06;
  localparam logic [7:0] CMD_PROX_RESULT  = 8'h08;
  localparam logic [7:0] CMD_LIGHT_RESULT = 8'h09;
  localparam logic [7:0] CMD_IRQ_CAUSE    = 8'h0D;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LCFG_IT_POS   = 6;
  localparam int LCFG_PERS_POS = 2;
  localparam int LCFG_IRQ_EN   = 1;
  localparam int PCFG_DUTY_POS = 6;
  localparam int PCFG_PERS_POS = 4;
  localparam int PCFG_SEL_POS  = 0;
  localparam int PCFG_MODE     = 8;
  localparam int PLIM_UPPER    = 8;
  localparam int IRQ_BYTE_POS  = 8;
  localparam int FLG_SAT       = 7;
  localparam int FLG_SUN       = 6;
  localparam int FLG_LLOW      = 5;
  localparam int FLG_LHIGH     = 4;
  localparam int FLG_NEAR      = 1;
  localparam int FLG_FAR       = 0;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] LIGHT_CFG_RST   = 16'h0000;
  localparam logic [15:0] LIGHT_UPPER_RST = 16'hFFFF;
  localparam logic [15:0] LIGHT_LOWER_RST = 16'h0000;
  localparam logic [15:0] PROX_CFG_RST    = 16'h0000;
  localparam logic [15:0] PROX_LIMITS_RST = 16'hFF00;
  localparam int          EMIT_PERIOD     = 16;
  // integration time in ms for codes 0..3 (0.024/0.012/0.006/0.003 lux per step)
  localparam int IT_MS_0 = 50;
  localparam int IT_MS_1 = 100;
  localparam int IT_MS_2 = 200;
  localparam int IT_MS_3 = 400;

  typedef enum logic [0:0] {
    H_IDLE = 1'b0,
    H_RUN  = 1'b1
  } lpt_host_e;
endpackage
`default_nettype wire

// [lpt_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lpt_link_if;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  logic irq_d_o;
  logic irq_d_oe_n;
  logic sda;
  logic irq_n;

  // ----------------------------------------------------------------
  // wired-and lines with pull-up
  // ----------------------------------------------------------------
  assign sda   = ~((~sda_h_oe_n & ~sda_h_o) | (~sda_d_oe_n & ~sda_d_o));
  assign irq_n = ~(~irq_d_oe_n & ~irq_d_o);

  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe_n, output irq_d_o, output irq_d_oe_n);
  modport host (output scl, output sda_h_o, output sda_h_oe_n, input sda, input irq_n);
endinterface
`default_nettype wire

// [lpt_host.sv]
`timescale 1ns/100ps
`default_nettype none
module lpt_host #(
  parameter int         SCL_HALF = lpt_pkg::SCL_HALF_DEF,
  parameter int         RD_PAUSE = lpt_pkg::RD_PAUSE_DEF,
  parameter logic [6:0] DEV_ADDR = lpt_pkg::LPT_DEV_ADDR
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  lpt_link_if.host         link,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic        cmd_write_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  output logic             irq_n_o
);
  import lpt_pkg::*;

  // line samples need the clock low/high phase to outlast the two sync flops
  if (SCL_HALF < 3 || SCL_HALF > 255) begin : g_half_chk
    $error("SCL_HALF out of range 3..255");
  end
  if (RD_PAUSE < 8 || RD_PAUSE > 255) begin : g_pause_chk
    $error("RD_PAUSE out of range 8..255");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lpt_host_e   st;
    logic [7:0]  div;
    logic        scl;
    logic [5:0]  bit_n;
    logic [32:0] tx;
    logic        rdop;
    logic [7:0]  pause;
    logic [15:0] rx;
    logic        rsp_v;
    logic [15:0] rsp_d;
    logic        sda_m;
    logic        sda_s;
    logic        irq_m;
    logic        irq_s;
    logic        sda_oe_n;
  } lpt_hs_s;

  lpt_hs_s hq;
  lpt_hs_s hd;
  logic    div_end;
  logic    fall_e;
  logic    rise_e;

  assign div_end     = hq.div == 8'(SCL_HALF - 1);
  assign fall_e      = hq.scl & div_end;
  assign rise_e      = ~hq.scl & div_end & (hq.pause == 8'h00);
  assign cmd_ready_o = (hq.st == H_IDLE) & fall_e & ~rst_i;

  // ----------------------------------------------------------------
  // clock divider, framing and answer capture
  // ----------------------------------------------------------------
  always_comb begin : hs_next
    hd       = hq;
    hd.rsp_v = 1'b0;
    hd.sda_m = link.sda;
    hd.sda_s = hq.sda_m;
    hd.irq_m = link.irq_n;
    hd.irq_s = hq.irq_m;
    // stretch holds the clock low so the device can fetch its answer word
    if (hq.pause != 8'h00) begin
      hd.pause = hq.pause - 8'h01;
    end else if (div_end) begin
      hd.div = 8'h00;
      hd.scl = ~hq.scl;
    end else begin
      hd.div = hq.div + 8'h01;
    end
    unique case (hq.st)
      H_IDLE: begin
        if (fall_e && cmd_valid_i) begin
          hd.st       = H_RUN;
          hd.tx       = {1'b0, DEV_ADDR, ~cmd_write_i, cmd_code_i,
                         cmd_write_i ? {cmd_wdata_i[7:0], cmd_wdata_i[15:8]} : 16'hFFFF};
          hd.rdop     = ~cmd_write_i;
          hd.bit_n    = 6'h00;
          hd.sda_oe_n = 1'b0;
        end
      end
      H_RUN: begin
        if (rise_e && hq.rdop && hq.bit_n > 6'(FRAME_HDR)) begin
          hd.rx = {hq.rx[14:0], hq.sda_s};
        end
        if (fall_e) begin
          if (hq.bit_n == 6'(FRAME_BITS)) begin
            hd.st       = H_IDLE;
            hd.sda_oe_n = 1'b1;
            hd.rsp_v    = 1'b1;
            hd.rsp_d    = hq.rdop ? {hq.rx[7:0], hq.rx[15:8]} : 16'h0000;
          end else begin
            hd.tx       = {hq.tx[31:0], 1'b1};
            hd.bit_n    = hq.bit_n + 6'h01;
            hd.sda_oe_n = hq.tx[31];
            if (hq.rdop && hq.bit_n == 6'(FRAME_HDR)) begin
              hd.pause = 8'(RD_PAUSE);
            end
          end
        end
      end
    endcase
    // in reset the clock toggles each cycle so the device domain sees its reset
    if (rst_i) begin
      hd          = '0;
      hd.st       = H_IDLE;
      hd.sda_oe_n = 1'b1;
      hd.irq_m    = 1'b1;
      hd.irq_s    = 1'b1;
      if (hq.scl) begin
        hd.scl = 1'b0;
      end else begin
        hd.scl = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin : hs_reg
    hq <= hd;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.scl        = hq.scl;
  assign link.sda_h_o    = 1'b0;
  assign link.sda_h_oe_n = hq.sda_oe_n;
  assign rsp_valid_o     = hq.rsp_v;
  assign rsp_data_o      = hq.rsp_d;
  assign irq_n_o         = hq.irq_s;
endmodule // lpt_host
`default_nettype wire

// [lpt_link_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module lpt_link_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda_h_o,
  input wire logic sda_h_oe_n,
  input wire logic sda_d_o,
  input wire logic sda_d_oe_n,
  input wire logic irq_d_o,
  input wire logic irq_d_oe_n,
  input wire logic sda,
  input wire logic irq_n
);
  import lpt_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // frame tracker, rebuilt from the wire alone
  // ----------------------------------------------------------------
  logic        scl_q;
  logic        busy_q;
  logic [5:0]  cnt_q;
  logic [15:0] hdr_q;
  logic [3:0]  up_q;
  logic        rise;
  logic        talk;
  assign rise = scl & ~scl_q;
  // device may only speak after a full read header carrying its address;
  // its first answer bit leaves at the 16th rise, one cycle before the tracker counts that rise
  assign talk = busy_q && (((cnt_q >= 6'd16) && (hdr_q[15:9] == LPT_DEV_ADDR) && hdr_q[8]) ||
                           (rise && (cnt_q == 6'd15) && (hdr_q[14:8] == LPT_DEV_ADDR) && hdr_q[7]));
  // header stops shifting at 16 bits so address and direction stay visible
  always_ff @(posedge ref_clk_i) begin
    scl_q <= scl;
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q  <= 6'h00;
      hdr_q  <= 16'h0000;
      up_q   <= 4'h0;
    end else begin
      if (up_q != 4'hF) up_q <= up_q + 4'h1;
      if (rise && !busy_q && !sda) begin
        busy_q <= 1'b1;
        cnt_q  <= 6'h00;
      end else if (rise && busy_q) begin
        cnt_q <= cnt_q + 6'h01;
        if (cnt_q < 6'd16) hdr_q <= {hdr_q[14:0], sda};
        if (cnt_q == 6'd31) busy_q <= 1'b0;
      end
    end
  end
  sequence s_high_phase;
    scl [*3] ##1 !scl;
  endsequence
  sequence s_read_pause;
    !scl [*8];
  endsequence
  AST_IRQ_OPEN_DRAIN: assert property (irq_d_o == 1'b0)
    else $error("irq line driven high");
  AST_SDA_OPEN_DRAIN: assert property (sda_d_o == 1'b0 && sda_h_o == 1'b0)
    else $error("data line driven high");
  AST_SCL_HIGH_TIME: assert property (up_q == 4'hF && $rose(scl) |-> s_high_phase)
    else $error("clock high phase length wrong");
  AST_HOST_SDA_HOLD: assert property (scl && $past(scl) |-> $stable(sda_h_oe_n))
    else $error("host data changed while clock high");
  AST_DEV_SDA_HOLD: assert property (!scl && !$past(scl) |-> $stable(sda_d_oe_n))
    else $error("device data changed while clock low");
  AST_DEV_ONLY_ANSWERS: assert property (!talk |-> sda_d_oe_n)
    else $error("device drove data outside its read answer");
  AST_READ_STRETCH: assert property (busy_q && cnt_q == 6'd16 && hdr_q[8] && $fell(scl) |-> s_read_pause)
    else $error("read pause too short");
  AST_IRQ_HELD: assert property ($fell(irq_n) |-> !irq_n [*3])
    else $error("irq pin glitched low");
endmodule // lpt_link_asserts
`default_nettype wire

// [test_light_proximity_threshold_irq.sv]
`timescale 1ns/100ps
`default_nettype none
module test_light_proximity_threshold_irq;
  import lpt_pkg::*;
  logic        ref_clk_i, rst_i, cmd_valid, cmd_ready, cmd_write, rsp_valid, irq_n;
  logic [7:0]  cmd_code, p_res;
  logic [15:0] cmd_wdata, rsp_data, l_res;
  logic        l_val, p_val, p_sat, p_sun, emit;
  logic [1:0]  it;
  int          errors, checks;
  logic [7:0]  rc [6] = '{CMD_LIGHT_CFG, CMD_LIGHT_UPPER, CMD_LIGHT_LOWER, CMD_PROX_CFG, CMD_PROX_LIMITS, CMD_IRQ_CAUSE};
  logic [15:0] rv [6] = '{LIGHT_CFG_RST, LIGHT_UPPER_RST, LIGHT_LOWER_RST, PROX_CFG_RST, PROX_LIMITS_RST, 16'h0000};
  lpt_link_if link ();
  lpt_dev lpt_dev_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link), .light_result_i(l_res),
    .light_valid_i(l_val), .prox_result_i(p_res), .prox_valid_i(p_val), .prox_saturated_i(p_sat),
    .sunlight_protect_i(p_sun), .emitter_drive_pin_o(emit), .light_integration_time_o(it));
  // short clock halves keep each frame near two hundred cycles
  lpt_host #(.SCL_HALF(3), .RD_PAUSE(8)) lpt_host_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write), .cmd_code_i(cmd_code),
    .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .irq_n_o(irq_n));
  lpt_link_asserts lpt_link_asserts_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl(link.scl),
    .sda_h_o(link.sda_h_o), .sda_h_oe_n(link.sda_h_oe_n), .sda_d_o(link.sda_d_o),
    .sda_d_oe_n(link.sda_d_oe_n), .irq_d_o(link.irq_d_o), .irq_d_oe_n(link.irq_d_oe_n),
    .sda(link.sda), .irq_n(link.irq_n));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // request held until the edge where ready is seen, answer taken at its own edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
    int n;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = c;
    cmd_wdata = d;
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (cmd_ready !== 1'b1 && n < 100);
    #1 cmd_valid = 1'b0;
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (rsp_valid !== 1'b1 && n < 1000);
    q = rsp_data;
    check("response", {15'h0, rsp_valid}, 16'h0001);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, c, d, q);
  endtask
  task automatic rd(input string name, input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] q;
    xfer(1'b0, c, 16'h0000, q);
    check(name, q, exp);
  endtask
  task automatic feed_l(input logic [15:0] v);
    l_res = v;
    l_val = 1'b1;
    tick(1);
    l_val = 1'b0;
    tick(1);
  endtask
  task automatic feed_p(input logic [7:0] v);
    p_res = v;
    p_val = 1'b1;
    tick(1);
    p_val = 1'b0;
    tick(1);
  endtask
  // pin passes two sync flops in the host, so let it settle first
  task automatic irq(input logic e);
    tick(8);
    check("irq pin", {15'h0, irq_n}, {15'h0, e});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1ms;
    errors++;
    conclude();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int n;
    {cmd_valid, cmd_write, cmd_code, cmd_wdata, l_res, l_val, p_res, p_val, p_sat, p_sun} = '0;
    rst_i = 1'b1;
    tick(4);
    rst_i = 1'b0;
    tick(40);
    for (i = 0; i < 6; i++) rd("reset value", rc[i], rv[i]);
    rd("unmapped", 8'h0A, 16'h0000);
    wr(CMD_LIGHT_UPPER, 16'h1234);
    rd("light upper", CMD_LIGHT_UPPER, 16'h1234);
    wr(CMD_LIGHT_LOWER, 16'h0100);
    rd("light lower", CMD_LIGHT_LOWER, 16'h0100);
    wr(CMD_PROX_LIMITS, 16'hC040);
    rd("prox limits", CMD_PROX_LIMITS, 16'hC040);
    feed_l(16'h2000);
    irq(1'b1);
    for (i = 0; i < 4; i++) begin
      wr(CMD_LIGHT_CFG, 16'(i << 6));
      rd("light cfg", CMD_LIGHT_CFG, 16'(i << 6));
      check("integration", {14'h0, it}, 16'(i));
    end
    feed_l(16'hA55A);
    rd("light word", CMD_LIGHT_RESULT, 16'hA55A);
    feed_p(8'h7E);
    rd("prox result", CMD_PROX_RESULT, 16'h007E);
    rd("cause clear", CMD_IRQ_CAUSE, 16'h0000);
    // light persistence 1/2/4/8, an inside result restarts the count
    for (i = 0; i < 4; i++) begin
      wr(CMD_LIGHT_CFG, 16'(i << 2) | 16'h0002);
      feed_l(16'h0800);
      repeat ((1 << i) - 1) feed_l(16'h2000);
      feed_l(16'h0800);
      repeat ((1 << i) - 1) feed_l(16'h2000);
      irq(1'b1);
      feed_l(16'h2000);
      irq(1'b0);
      rd("upper while low", CMD_LIGHT_UPPER, 16'h1234);
      rd("cause high", CMD_IRQ_CAUSE, 16'h1000);
      irq(1'b1);
    end
    wr(CMD_LIGHT_CFG, 16'h0002);
    feed_l(16'h0050);
    irq(1'b0);
    rd("cause low", CMD_IRQ_CAUSE, 16'h2000);
    // proximity persistence 1..4 on both sides, hysteresis between limits
    for (i = 0; i < 4; i++) begin
      wr(CMD_PROX_CFG, 16'(i << 4) | 16'h0003);
      feed_p(8'h80);
      repeat (i) feed_p(8'hD0);
      feed_p(8'h80);
      repeat (i) feed_p(8'hD0);
      irq(1'b1);
      feed_p(8'hD0);
      irq(1'b0);
      rd("cause near", CMD_IRQ_CAUSE, 16'h0200);
      repeat (i + 1) feed_p(8'h80);
      irq(1'b1);
      repeat (i + 1) feed_p(8'h20);
      irq(1'b0);
      rd("cause far", CMD_IRQ_CAUSE, 16'h0100);
    end
    p_sat = 1'b1;
    tick(1);
    p_sat = 1'b0;
    irq(1'b0);
    rd("cause saturation", CMD_IRQ_CAUSE, 16'h8000);
    p_sun = 1'b1;
    tick(1);
    p_sun = 1'b0;
    rd("cause sunlight", CMD_IRQ_CAUSE, 16'h4000);
    // logic output mode: pin follows proximity state only
    wr(CMD_PROX_CFG, 16'h0103);
    feed_l(16'h2000);
    irq(1'b1);
    feed_p(8'hD0);
    irq(1'b0);
    rd("limits in logic mode", CMD_PROX_LIMITS, 16'hC040);
    feed_p(8'h80);
    irq(1'b0);
    feed_p(8'h20);
    irq(1'b1);
    wr(CMD_PROX_CFG, 16'h0003);
    irq(1'b0);
    wr(CMD_LIGHT_CFG, 16'h0000);
    rd("cause pending", CMD_IRQ_CAUSE, 16'h1300);
    irq(1'b1);
    // emitter on time over four whole periods of sixteen cycles
    for (i = 0; i < 4; i++) begin
      wr(CMD_PROX_CFG, 16'(i << 6));
      tick(8);
      n = 0;
      repeat (64) begin
        tick(1);
        if (emit === 1'b1) n++;
      end
      check("emitter on time", 16'(n), 16'(8 << i));
    end
    conclude();
  end
endmodule // test_light_proximity_threshold_irq
`default_nettype wire
